// File: hw/core_clock_divider.sv
// Purpose: Binary core clock divider producing one-cycle core clock enables
// Assumes: sys_en is a one-cycle pulse at the PLL system rate, never two back to back
// Notes: A new divider code takes effect only at the end of a full core period
`timescale 1ns/1ps
module core_clock_divider #(
    parameter int SEL_W = 3
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic sys_en,
    input wire logic halt,
    input wire logic [SEL_W-1:0] sel,
    output logic core_en,
    output logic [SEL_W-1:0] active_sel
);
    import pll_clock_pkg::*;

    localparam int CNT_W = (1 << SEL_W);

    initial begin
        if (SEL_W < 1 || SEL_W > 4) begin
            $error("core_clock_divider: SEL_W must be 1 to 4");
        end
    end

    function automatic logic [CNT_W-1:0] div_limit(input logic [SEL_W-1:0] s);
        div_limit = CNT_W'((1 << s) - 1);
    endfunction

    logic [CNT_W-1:0] cnt;
    logic at_end;

    assign at_end = (cnt >= div_limit(active_sel));

    // ----------------------------------------------------------------
    // Period counter; selection latched only at a period boundary
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= '0;
            active_sel <= SEL_W'(PLL_CTRL_RESET[DIV_MSB:DIV_LSB]);
            core_en <= 1'b0;
        end else begin
            core_en <= 1'b0;
            if (sys_en && !halt) begin
                if (at_end) begin
                    cnt <= '0;
                    active_sel <= sel;
                    core_en <= 1'b1;
                end else begin
                    cnt <= cnt + 1'b1;
                end
            end
        end
    end

    AST_DIV_ZERO_EVERY: assert property (@(posedge clk) disable iff (!resetn)
        (sys_en && !halt && active_sel == '0) |=> core_en)
        else $error("code zero did not pass every system pulse");

    AST_DIV_NO_RUNT: assert property (@(posedge clk) disable iff (!resetn)
        core_en |-> (active_sel == $past(sel)))
        else $error("divider code changed away from a period boundary");

    AST_DIV_HALVES: assert property (@(posedge clk) disable iff (!resetn)
        (sys_en && !halt && !at_end) |=> !core_en)
        else $error("core enable issued before the period ended");

endmodule

// File: hw/pll_clock_pkg.sv
// Purpose: Shared constants and types for the PLL and core clock control block
// Assumes: One 100 MHz clock; the control register sits on the 8-bit special-function bus
// Notes: Every offset, field position, reset value and timing count lives here
package pll_clock_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] PLL_CTRL_ADDR = 8'hd7;
    localparam logic [7:0] PLL_CTRL_RESET = 8'h53;
    localparam int OSC_HALT_BIT = 7;
    localparam int LOCK_BIT = 6;
    localparam int RSVD_HI_BIT = 5;
    localparam int RSVD_LO_BIT = 4;
    localparam int FAST_IRQ_BIT = 3;
    localparam int DIV_MSB = 2;
    localparam int DIV_LSB = 0;
    localparam logic [2:0] DIV_FASTEST = 3'h0;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int XTAL_HZ = 32_768;
    localparam int PLL_MULT = 512;
    localparam int SYS_HZ = PLL_MULT * XTAL_HZ;
    localparam int XTAL_PERIOD_CYC = CLK_HZ / XTAL_HZ;
    localparam int TRACK_TOL_PCT = 20;
    localparam int TRACK_MIN_CYC = (XTAL_PERIOD_CYC * (100 - TRACK_TOL_PCT) + 99) / 100;
    localparam int TRACK_MAX_CYC = (XTAL_PERIOD_CYC * (100 + TRACK_TOL_PCT)) / 100;
    localparam int LOCK_TIMEOUT_CYC = 2 * XTAL_PERIOD_CYC;
    localparam int ACC_W = 27;
    localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CLK_HZ);
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(SYS_HZ);

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } sfr_req_s;

    typedef struct packed {
        logic osc_halt;
        logic [1:0] rsvd;
        logic fast_irq;
        logic [2:0] div_sel;
    } ctrl_s;

    typedef enum logic [1:0] {
        LK_WAIT_EDGE,
        LK_MEASURE,
        LK_DONE
    } lock_state_e;

endpackage

// File: hw/pll_core_clock_control.sv
// Purpose: PLL tracking check, oscillator power-down control and core clock selection
// Assumes: xtal_in is the crystal clock level sampled on clk; isr_active is high in service
// Notes: System and core clocks are one-cycle enables derived from the 100 MHz clock
`timescale 1ns/1ps
// Contract
// - Halt bit set stops crystal oscillator during power-down.
// - Halt bit clear keeps oscillator running in power-down for interval counter.
// - Bit 6 is read-only tracking flag; writes do not change it.
// - Flag set at power-on when PLL tracks the crystal.
// - Crystal lost after lock rails PLL and halts core.
// - Flag cleared at power-on when crystal absent or tracking fails; PLL free-runs.
// - Fast interrupt bit set services interrupts at fastest core clock.
// - After interrupt return core goes back to divider-selected rate.
// - Fast interrupt bit clear services interrupts at divider rate.
// - Three-bit divider selects core rate; zero gives undivided PLL clock.
// - Control register reads hexadecimal 53 after power-on reset.
// - Each higher divider code halves the core clock.
// - PLL runs at 512 times the 32.768 kHz crystal.
module pll_core_clock_control #(
    parameter int LOCK_TIMEOUT = pll_clock_pkg::LOCK_TIMEOUT_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input pll_clock_pkg::sfr_req_s sfr,
    output logic sfr_hit,
    output logic [7:0] sfr_rdata,
    input wire logic xtal_in,
    input wire logic power_down_mode,
    input wire logic isr_active,
    output logic xtal_osc_enable,
    output logic pll_locked,
    output logic pll_free_run,
    output logic pll_railed,
    output logic sys_clk_en,
    output logic core_clk_en,
    output logic fast_clock_active
);
    import pll_clock_pkg::*;

    initial begin
        if (LOCK_TIMEOUT <= TRACK_MAX_CYC || LOCK_TIMEOUT > 65535) begin
            $error("pll_core_clock_control: LOCK_TIMEOUT out of range");
        end
    end

    ctrl_s ctrl;
    logic lock;
    lock_state_e lk_state;
    logic [15:0] lk_cnt;
    logic xtal_q;
    logic xtal_rise;
    logic lk_timeout;
    logic [ACC_W-1:0] acc;
    logic [ACC_W:0] acc_sum;
    logic [2:0] eff_sel;
    logic [2:0] active_sel;
    logic core_halt;

    // ----------------------------------------------------------------
    // Register access
    // ----------------------------------------------------------------
    assign sfr_hit = (sfr.addr == PLL_CTRL_ADDR);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl <= ctrl_s'({PLL_CTRL_RESET[7], PLL_CTRL_RESET[5:0]});
        end else if (sfr.wr && sfr_hit) begin
            ctrl.osc_halt <= sfr.wdata[OSC_HALT_BIT];
            ctrl.rsvd <= sfr.wdata[RSVD_HI_BIT:RSVD_LO_BIT];
            ctrl.fast_irq <= sfr.wdata[FAST_IRQ_BIT];
            ctrl.div_sel <= sfr.wdata[DIV_MSB:DIV_LSB];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sfr_rdata <= 8'h00;
        end else if (sfr.rd && sfr_hit) begin
            sfr_rdata <= {ctrl.osc_halt, lock, ctrl.rsvd, ctrl.fast_irq, ctrl.div_sel};
        end
    end

    // ----------------------------------------------------------------
    // Oscillator power-down
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            xtal_osc_enable <= 1'b1;
        end else begin
            xtal_osc_enable <= !(power_down_mode && ctrl.osc_halt);
        end
    end

    // ----------------------------------------------------------------
    // Crystal tracking check
    // ----------------------------------------------------------------
    assign xtal_rise = xtal_in && !xtal_q;
    assign lk_timeout = (lk_cnt >= 16'(LOCK_TIMEOUT));

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // Starts high so a crystal already high at release is not an edge
            xtal_q <= 1'b1;
        end else begin
            xtal_q <= xtal_in;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lk_state <= LK_WAIT_EDGE;
            lk_cnt <= '0;
            lock <= PLL_CTRL_RESET[LOCK_BIT];
            pll_railed <= 1'b0;
        end else begin
            case (lk_state)
                LK_WAIT_EDGE: begin
                    if (xtal_rise) begin
                        lk_state <= LK_MEASURE;
                        lk_cnt <= '0;
                    end else if (lk_timeout) begin
                        lock <= 1'b0;
                        lk_state <= LK_DONE;
                    end else begin
                        lk_cnt <= lk_cnt + 1'b1;
                    end
                end
                LK_MEASURE: begin
                    if (xtal_rise) begin
                        lock <= (lk_cnt >= 16'(TRACK_MIN_CYC - 1))
                                && (lk_cnt <= 16'(TRACK_MAX_CYC - 1));
                        lk_state <= LK_DONE;
                        lk_cnt <= '0;
                    end else if (lk_timeout) begin
                        lock <= 1'b0;
                        lk_state <= LK_DONE;
                    end else begin
                        lk_cnt <= lk_cnt + 1'b1;
                    end
                end
                LK_DONE: begin
                    if (xtal_rise) begin
                        lk_cnt <= '0;
                    end else if (lock && lk_timeout) begin
                        pll_railed <= 1'b1;
                    end else if (!lk_timeout) begin
                        lk_cnt <= lk_cnt + 1'b1;
                    end
                end
                default: begin
                    lk_state <= LK_WAIT_EDGE;
                end
            endcase
        end
    end

    assign pll_locked = lock;
    assign pll_free_run = !lock;
    assign core_halt = pll_railed;

    // ----------------------------------------------------------------
    // System clock enable at 512 times the crystal rate
    // ----------------------------------------------------------------
    assign acc_sum = {1'b0, acc} + {1'b0, ACC_STEP};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc <= '0;
            sys_clk_en <= 1'b0;
        end else if (core_halt) begin
            sys_clk_en <= 1'b0;
        end else if (acc_sum >= {1'b0, ACC_MOD}) begin
            acc <= ACC_W'(acc_sum - {1'b0, ACC_MOD});
            sys_clk_en <= 1'b1;
        end else begin
            acc <= acc_sum[ACC_W-1:0];
            sys_clk_en <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Core clock selection and divider
    // ----------------------------------------------------------------
    always_comb begin
        if (ctrl.fast_irq && isr_active) begin
            eff_sel = DIV_FASTEST;
        end else begin
            eff_sel = ctrl.div_sel;
        end
    end

    core_clock_divider #(
        .SEL_W(3)
    ) u_div (
        .clk(clk),
        .resetn(resetn),
        .sys_en(sys_clk_en),
        .halt(core_halt),
        .sel(eff_sel),
        .core_en(core_clk_en),
        .active_sel(active_sel)
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fast_clock_active <= 1'b0;
        end else begin
            fast_clock_active <= ctrl.fast_irq && isr_active && (active_sel == DIV_FASTEST);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_OSC_HALT: assert property (@(posedge clk) disable iff (!resetn)
        (power_down_mode && ctrl.osc_halt) |=> !xtal_osc_enable)
        else $error("oscillator still enabled in power-down with halt set");

    AST_OSC_RUN: assert property (@(posedge clk) disable iff (!resetn)
        (power_down_mode && !ctrl.osc_halt) |=> xtal_osc_enable)
        else $error("oscillator stopped in power-down with halt clear");

    AST_LOCK_READ_ONLY: assert property (@(posedge clk) disable iff (!resetn)
        (lk_state == LK_DONE && sfr.wr && sfr_hit) |=> (lock == $past(lock)))
        else $error("write changed the tracking flag");

    AST_READ_VALUE: assert property (@(posedge clk) disable iff (!resetn)
        (sfr.rd && sfr_hit) |=> (sfr_rdata == {$past(ctrl.osc_halt), $past(lock),
            $past(ctrl.rsvd), $past(ctrl.fast_irq), $past(ctrl.div_sel)}))
        else $error("register read returned wrong contents");

    AST_NO_CRYSTAL: assert property (@(posedge clk) disable iff (!resetn)
        (lk_state == LK_WAIT_EDGE && lk_timeout && !xtal_rise) |=> (!lock && pll_free_run))
        else $error("tracking flag not cleared with no crystal");

    AST_RAIL_HALT: assert property (@(posedge clk) disable iff (!resetn)
        pll_railed |=> (!sys_clk_en ##1 !core_clk_en))
        else $error("core clock still running after the PLL railed");

    AST_FAST_SEL: assert property (@(posedge clk) disable iff (!resetn)
        (ctrl.fast_irq && isr_active) |-> (eff_sel == DIV_FASTEST))
        else $error("fast interrupt not using fastest core clock");

    AST_SLOW_SEL: assert property (@(posedge clk) disable iff (!resetn)
        (!ctrl.fast_irq || !isr_active) |-> (eff_sel == ctrl.div_sel))
        else $error("core clock not following the divider field");

    AST_TRACK_PASS: assert property (@(posedge clk) disable iff (!resetn)
        (lk_state == LK_MEASURE && xtal_rise && lk_cnt == 16'(XTAL_PERIOD_CYC - 1))
        |=> (lock && lk_state == LK_DONE))
        else $error("nominal crystal period did not set the tracking flag");

    AST_SYS_SPACED: assert property (@(posedge clk) disable iff (!resetn)
        sys_clk_en |=> !sys_clk_en)
        else $error("system clock enable high on two cycles in a row");

    AST_SYS_LIVE: assert property (@(posedge clk) disable iff (!resetn)
        (!pll_railed && !sys_clk_en) |-> ##[1:7] (sys_clk_en || pll_railed))
        else $error("system clock enable missing while the PLL runs");

    AST_CORE_ON_SYS: assert property (@(posedge clk) disable iff (!resetn)
        core_clk_en |-> $past(sys_clk_en))
        else $error("core clock enable not aligned to a system pulse");

    AST_RAIL_STICKY: assert property (@(posedge clk) disable iff (!resetn)
        pll_railed |=> pll_railed)
        else $error("railed state cleared without reset");

    AST_RAIL_NEEDS_LOCK: assert property (@(posedge clk) disable iff (!resetn)
        $rose(pll_railed) |-> pll_locked)
        else $error("PLL railed without an earlier lock");

    AST_NO_RAIL_UNLOCKED: assert property (@(posedge clk) disable iff (!resetn)
        (!pll_locked && !pll_railed) |=> !pll_railed)
        else $error("unlocked PLL reported as railed");

    AST_LOCK_STEADY: assert property (@(posedge clk) disable iff (!resetn)
        (lk_state == LK_DONE) |=> $stable(lock))
        else $error("tracking flag changed after the check finished");

    AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (!resetn)
        !(sfr.rd && sfr_hit) |=> $stable(sfr_rdata))
        else $error("read data changed without a register read");

    AST_OSC_AWAKE: assert property (@(posedge clk) disable iff (!resetn)
        !power_down_mode |=> xtal_osc_enable)
        else $error("oscillator stopped outside power-down");

    AST_FAST_HOLD: assert property (@(posedge clk) disable iff (!resetn)
        (ctrl.fast_irq && isr_active && sys_clk_en && !pll_railed
            && active_sel == DIV_FASTEST) |=> (core_clk_en && active_sel == DIV_FASTEST))
        else $error("fast interrupt clock skipped a system pulse");

    AST_FAST_EXIT: assert property (@(posedge clk) disable iff (!resetn)
        ($fell(isr_active) && ctrl.fast_irq && !pll_railed
            && active_sel == DIV_FASTEST) |-> ##[1:8] (active_sel == ctrl.div_sel))
        else $error("core clock did not return to the divider rate");

    AST_SLOW_FLAG: assert property (@(posedge clk) disable iff (!resetn)
        (!ctrl.fast_irq || !isr_active) |=> !fast_clock_active)
        else $error("fast clock flagged without fast interrupt service");

endmodule

// File: tb/pll_core_clock_control_tb.sv
// Purpose: Self-checking bench for the PLL tracking flag, register and core clock divider
// Assumes: Bench drives every input at the falling edge of clk; crystal level from a counter
// Notes: LOCK_TIMEOUT is shortened to 4000 cycles so loss of crystal is seen quickly
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin $display("BAD %s exp %h got %h", nm, ex, gt); miscompares++; end end
module pll_core_clock_control_tb;
    import pll_clock_pkg::*;
    localparam int TMO = 4000;

    logic clk = 1'b0;
    logic resetn = 1'b0;
    sfr_req_s sfr = '0;
    logic xtal_in = 1'b0;
    logic power_down_mode = 1'b0;
    logic isr_active = 1'b0;
    logic sfr_hit;
    logic [7:0] sfr_rdata;
    logic xtal_osc_enable;
    logic pll_locked;
    logic pll_free_run;
    logic pll_railed;
    logic sys_clk_en;
    logic core_clk_en;
    logic fast_clock_active;
    logic xtal_run = 1'b1;
    int xcnt = 0;
    int miscompares = 0;
    int tests_run = 0;
    int seed = 28585;
    logic sys_prev = 1'b0;
    logic core_prev = 1'b0;

    always #5 clk = ~clk;

    pll_core_clock_control #(.LOCK_TIMEOUT(TMO)) dut (
        .clk(clk),
        .resetn(resetn),
        .sfr(sfr),
        .sfr_hit(sfr_hit),
        .sfr_rdata(sfr_rdata),
        .xtal_in(xtal_in),
        .power_down_mode(power_down_mode),
        .isr_active(isr_active),
        .xtal_osc_enable(xtal_osc_enable),
        .pll_locked(pll_locked),
        .pll_free_run(pll_free_run),
        .pll_railed(pll_railed),
        .sys_clk_en(sys_clk_en),
        .core_clk_en(core_clk_en),
        .fast_clock_active(fast_clock_active)
    );

    // ----------------------------------------------------------------
    // Crystal model and core pulse monitor
    // ----------------------------------------------------------------
    always @(negedge clk) begin
        if (xtal_run) begin
            xcnt <= (xcnt == XTAL_PERIOD_CYC - 1) ? 0 : xcnt + 1;
            xtal_in <= (xcnt < XTAL_PERIOD_CYC / 2);
        end else begin
            xtal_in <= 1'b0;
        end
    end

    always @(negedge clk) begin
        if (resetn && core_clk_en) `CHK("core_after_sys", 2'b10, {sys_prev, core_prev})
        sys_prev <= sys_clk_en;
        core_prev <= core_clk_en;
    end

    // ----------------------------------------------------------------
    // Tasks and expectations
    // ----------------------------------------------------------------
    function automatic logic [7:0] exp_read(input logic [7:0] w, input logic lk);
        return {w[7], lk, w[5:0]};
    endfunction

    task automatic tally_and_finish();
        if (miscompares == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr.addr = a;
        sfr.wdata = d;
        sfr.wr = 1'b1;
        @(negedge clk);
        sfr.wr = 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] q);
        @(negedge clk);
        sfr.addr = a;
        sfr.rd = 1'b1;
        @(negedge clk);
        sfr.rd = 1'b0;
        @(negedge clk);
        q = sfr_rdata;
    endtask

    task automatic wait_core();
        int k;
        for (k = 0; k < 2000; k++) begin
            @(negedge clk);
            if (core_clk_en) break;
        end
        if (k == 2000) begin
            miscompares++;
            tally_and_finish();
        end
    endtask

    // Sys pulses between two core pulses, after one settling period
    task automatic period(output int n);
        int k;
        n = 0;
        wait_core();
        wait_core();
        for (k = 0; k < 2000; k++) begin
            @(negedge clk);
            if (core_clk_en) break;
            n += int'(sys_clk_en);
        end
        if (k == 2000) begin
            miscompares++;
            tally_and_finish();
        end
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] q;
        logic [7:0] q2;
        logic [7:0] d;
        int n;
        int i;
        longint lo;
        lo = longint'(10000) * SYS_HZ / CLK_HZ;
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        rd_reg(PLL_CTRL_ADDR, q);
        `CHK("reset_value", PLL_CTRL_RESET, q)
        `CHK("osc_on", 1'b1, xtal_osc_enable)
        repeat (8000) @(negedge clk);
        `CHK("locked", 1'b1, pll_locked)
        `CHK("free_run", 1'b0, pll_free_run)
        n = 0;
        repeat (10000) begin
            @(negedge clk);
            n += int'(sys_clk_en);
        end
        `CHK("sys_rate", 1'b1, (n >= lo && n <= lo + 1))
        for (i = 0; i < 12; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'h8f : 8'($random(seed)) & 8'hcf;
            wr_reg(PLL_CTRL_ADDR, d);
            wr_reg(8'hd6, ~d);
            rd_reg(PLL_CTRL_ADDR, q);
            `CHK("readback", exp_read(d, 1'b1), q)
        end
        rd_reg(8'hd6, q2);
        `CHK("unmapped_read", q, q2)
        `CHK("unmapped_hit", 1'b0, sfr_hit)
        wr_reg(PLL_CTRL_ADDR, 8'h83);
        power_down_mode = 1'b1;
        repeat (3) @(negedge clk);
        `CHK("osc_halted", 1'b0, xtal_osc_enable)
        wr_reg(PLL_CTRL_ADDR, 8'h03);
        repeat (3) @(negedge clk);
        `CHK("osc_kept", 1'b1, xtal_osc_enable)
        power_down_mode = 1'b0;
        for (i = 7; i >= 0; i--) begin
            wr_reg(PLL_CTRL_ADDR, 8'(i));
            period(n);
            `CHK("core_period", 1 << i, n)
        end
        wr_reg(PLL_CTRL_ADDR, 8'h0d);
        isr_active = 1'b1;
        period(n);
        `CHK("fast_period", 1, n)
        `CHK("fast_flag", 1'b1, fast_clock_active)
        isr_active = 1'b0;
        period(n);
        `CHK("after_return", 32, n)
        wr_reg(PLL_CTRL_ADDR, 8'h05);
        isr_active = 1'b1;
        period(n);
        `CHK("slow_isr", 32, n)
        `CHK("slow_flag", 1'b0, fast_clock_active)
        isr_active = 1'b0;
        xtal_run = 1'b0;
        repeat (TMO + 500) @(negedge clk);
        `CHK("railed", 1'b1, pll_railed)
        n = 0;
        repeat (300) begin
            @(negedge clk);
            n += int'(sys_clk_en) + int'(core_clk_en);
        end
        `CHK("core_stopped", 0, n)
        resetn = 1'b0;
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        repeat (TMO + 1000) @(negedge clk);
        `CHK("no_lock", 1'b0, pll_locked)
        `CHK("free_running", 1'b1, pll_free_run)
        `CHK("not_railed", 1'b0, pll_railed)
        rd_reg(PLL_CTRL_ADDR, q);
        `CHK("unlocked_read", 8'h13, q)
        tally_and_finish();
    end
endmodule
